// ---- verilog/acp_device.sv ----
`timescale 1ns/1ps
// What this block does
// - Select falling after reset chooses SPI mode
// - Two-wire mode needs select pin tied static
// - Sample input rising edge, change output falling
// - Respond only to chip address 1001111
// - Eighth bit: low writes, high reads
// - Write: next byte loads pointer, MSB first
// - Store following byte at pointer register
// - Output stays undriven during writes
// - Host sets pointer by partial write first
// - Read: drive MSB on next falling edge
// - Pointer advances after every data byte
// - Link runs unrelated to audio clocks
// - Host drives select, clock, input; device output
// - Reset holds port and registers at defaults
module acp_device
  import acp_pkg::*;
(
  input  wire logic         clk_i,        // System clock
  input  wire logic         rst_i,        // Asynchronous reset, active high
  acp_link_if.dev           link,         // Control port pins
  output logic              spi_mode_o,   // SPI control mode chosen
  output logic              wr_stb_o,     // One-cycle pulse per stored byte
  output logic [7:0]        wr_addr_o,    // Register pointer of that byte
  output logic [7:0]        wr_data_o     // Value stored
);

  // Per-frame state, cleared whenever select is high
  typedef struct packed {
    acp_phase_t ph;        // Which byte of the frame is arriving
    logic [2:0] cnt;       // Bit position inside the byte
    logic [6:0] sh;        // Bits received so far
    logic [7:0] rd_byte;   // Byte being shifted back to the host
  } acp_frame_t;

  // State that outlives a frame
  typedef struct packed {
    logic [7:0]                ptr;      // Register pointer
    logic [ACP_NREG-1:0][7:0]  regs;     // Register store
    logic                      wr_tgl;   // Flips once per stored byte
    logic [7:0]                wr_addr;  // Held address of last store
    logic [7:0]                wr_data;  // Held data of last store
  } acp_store_t;

  // Output stage, moved on the falling link edge
  typedef struct packed {
    logic dout;            // Bit on the serial output
    logic oe_n;            // Low while driving
  } acp_out_t;

  // System-clock side
  typedef struct packed {
    logic       cs_s1;     // Select synchroniser, first stage
    logic       cs_s2;     // Select synchroniser, second stage
    logic       cs_prev;   // Previous synchronised select
    logic       spi_mode;  // Sticky mode flag
    logic       tg_s1;     // Store toggle, first stage
    logic       tg_s2;     // Store toggle, second stage
    logic       tg_prev;   // Previous synchronised toggle
    logic       wr_stb;    // Store pulse
    logic [7:0] wr_addr;   // Captured address
    logic [7:0] wr_data;   // Captured data
  } acp_sys_t;

  acp_frame_t fr_r, fr_nxt;   // Frame state
  acp_store_t st_r, st_nxt;   // Store state
  acp_out_t   out_r, out_nxt; // Output stage
  acp_sys_t   sy_r, sy_nxt;   // System-side state
  logic       frame_rst;      // Frame clear: reset or select high
  logic [7:0] byte_v;         // Byte completed on this edge

  // Read of the store; pointers past the last register read as zero
  function automatic logic [7:0] reg_rd(input logic [ACP_NREG-1:0][7:0] r, input logic [7:0] p);
    if (p < 8'(ACP_NREG)) begin
      reg_rd = r[p[ACP_IDX_W-1:0]];
    end else begin
      reg_rd = 8'h00;
    end
  endfunction

  // Select high ends a frame even though the link clock stops with it
  assign frame_rst = rst_i | link.addr_lsb_or_select_pin_n;

  // Link-side next state
  always_comb begin
    fr_nxt = fr_r;
    st_nxt = st_r;
    byte_v = {fr_r.sh, link.control_serial_in};
    fr_nxt.sh  = byte_v[6:0];
    fr_nxt.cnt = fr_r.cnt + 3'h1;
    if (fr_r.cnt == ACP_BIT_LAST) begin
      unique case (fr_r.ph)
        ACP_PH_ADDR: begin
          // Foreign address: stay silent until select rises
          if (byte_v[7:1] != ACP_CHIP_ADDR) begin
            fr_nxt.ph = ACP_PH_IGNORE;
          end else if (byte_v[0] == ACP_RW_READ) begin
            fr_nxt.ph      = ACP_PH_RDATA;
            fr_nxt.rd_byte = reg_rd(st_r.regs, st_r.ptr);
          end else begin
            fr_nxt.ph = ACP_PH_PTR;
          end
        end
        ACP_PH_PTR: begin
          // Pointer byte, MSB first through the shifter
          st_nxt.ptr = byte_v;
          fr_nxt.ph  = ACP_PH_WDATA;
        end
        ACP_PH_WDATA: begin
          // Store, report, advance
          for (int i = 0; i < ACP_NREG; i++) begin
            if (st_r.ptr == 8'(i)) begin
              st_nxt.regs[i] = byte_v;
            end
          end
          st_nxt.wr_addr = st_r.ptr;
          st_nxt.wr_data = byte_v;
          st_nxt.wr_tgl  = ~st_r.wr_tgl;
          st_nxt.ptr     = acp_ptr_inc(st_r.ptr);
        end
        ACP_PH_RDATA: begin
          // Byte fully sent: advance and fetch the next register
          st_nxt.ptr     = acp_ptr_inc(st_r.ptr);
          fr_nxt.rd_byte = reg_rd(st_r.regs, acp_ptr_inc(st_r.ptr));
        end
        ACP_PH_IGNORE: begin
          // Nothing happens until the frame ends
          fr_nxt.ph = ACP_PH_IGNORE;
        end
        default: begin
          fr_nxt.ph = ACP_PH_IGNORE;
        end
      endcase
    end
  end

  // Output value for the next falling edge; only a read phase drives
  always_comb begin
    out_nxt.oe_n = (fr_r.ph != ACP_PH_RDATA);
    out_nxt.dout = fr_r.rd_byte[ACP_BIT_LAST - fr_r.cnt];
  end

  // Frame registers on the rising link edge
  always_ff @(posedge link.control_bit_clock or posedge frame_rst) begin
    if (frame_rst) begin
      fr_r <= '{ph: ACP_PH_ADDR, cnt: 3'h0, sh: 7'h00, rd_byte: 8'h00};
    end else begin
      fr_r <= fr_nxt;
    end
  end

  // Store registers on the rising link edge; only reset clears them
  always_ff @(posedge link.control_bit_clock or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{ptr: ACP_PTR_RESET, regs: {ACP_NREG{ACP_REG_RESET}},
                wr_tgl: 1'b0, wr_addr: 8'h00, wr_data: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Output stage changes on the falling link edge; reset or select high clears it
  always_ff @(negedge link.control_bit_clock or posedge frame_rst) begin
    if (frame_rst) begin
      out_r <= '{dout: 1'b0, oe_n: 1'b1};
    end else begin
      out_r <= out_nxt;
    end
  end

  assign link.control_serial_out      = out_r.dout;
  assign link.control_serial_out_oe_n = out_r.oe_n;

  // System side: mode detection and store reporting
  always_comb begin
    sy_nxt         = sy_r;
    sy_nxt.cs_s1   = link.addr_lsb_or_select_pin_n;
    sy_nxt.cs_s2   = sy_r.cs_s1;
    sy_nxt.cs_prev = sy_r.cs_s2;
    // A falling select seen after reset means a host is clocking frames
    if (sy_r.cs_prev && !sy_r.cs_s2) begin
      sy_nxt.spi_mode = 1'b1;
    end
    sy_nxt.tg_s1   = st_r.wr_tgl;
    sy_nxt.tg_s2   = sy_r.tg_s1;
    sy_nxt.tg_prev = sy_r.tg_s2;
    sy_nxt.wr_stb  = 1'b0;
    // Held address and data are stable for a whole byte, so capture is safe
    if (sy_r.tg_s2 != sy_r.tg_prev) begin
      sy_nxt.wr_stb  = 1'b1;
      sy_nxt.wr_addr = st_r.wr_addr;
      sy_nxt.wr_data = st_r.wr_data;
    end
  end

  // System-side registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sy_r <= '0;
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign spi_mode_o = sy_r.spi_mode;
  assign wr_stb_o   = sy_r.wr_stb;
  assign wr_addr_o  = sy_r.wr_addr;
  assign wr_data_o  = sy_r.wr_data;

endmodule

// ---- verilog/acp_pkg.sv ----
package acp_pkg;

  // Link framing
  localparam logic [6:0] ACP_CHIP_ADDR  = 7'h4F;   // Fixed chip address pattern 1001111
  localparam logic       ACP_RW_WRITE   = 1'h0;    // Flag value for a register write
  localparam logic       ACP_RW_READ    = 1'h1;    // Flag value for a register read
  localparam logic [2:0] ACP_BIT_LAST   = 3'h7;    // Bit index that completes a byte
  localparam int         ACP_BYTE_W     = 8;       // Byte and pointer width

  // Register store
  localparam int         ACP_NREG       = 16;      // Registers held by the device
  localparam int         ACP_IDX_W      = 4;       // Index bits used from the pointer
  localparam logic [7:0] ACP_REG_RESET  = 8'h00;   // Default value of every register
  localparam logic [7:0] ACP_PTR_RESET  = 8'h00;   // Default pointer value

  // Host frame lengths in bits
  localparam logic [4:0] ACP_BITS_WRITE = 5'h18;   // Address, pointer, one data byte
  localparam logic [4:0] ACP_BITS_SHORT = 5'h10;   // Address plus one byte

  // Host timing, figures as printed, converted at the 200 MHz system clock
  localparam int ACP_CLK_MHZ     = 200;            // System clock rate
  localparam int ACP_SCK_MAX_KHZ = 6000;           // Highest link clock rate
  localparam int ACP_SCK_HALF_NS = (1000000 + 2 * ACP_SCK_MAX_KHZ - 1) / (2 * ACP_SCK_MAX_KHZ);
  localparam int ACP_SCK_HALF_CYC = (ACP_SCK_HALF_NS * ACP_CLK_MHZ + 999) / 1000;
  localparam int ACP_CSH_NS      = 1000;           // Select high time between frames
  localparam int ACP_CSH_CYC     = (ACP_CSH_NS * ACP_CLK_MHZ + 999) / 1000;
  localparam int ACP_SRS_NS      = 500;            // Reset release to first select fall
  localparam int ACP_SRS_CYC     = (ACP_SRS_NS * ACP_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] ACP_HALF_LOAD = 8'(ACP_SCK_HALF_CYC - 1);
  localparam logic [7:0] ACP_CSH_LOAD  = 8'(ACP_CSH_CYC - 1);
  localparam logic [7:0] ACP_SRS_LOAD  = 8'(ACP_SRS_CYC - 1);

  // Device frame phases
  typedef enum logic [2:0] {
    ACP_PH_ADDR   = 3'b000,
    ACP_PH_PTR    = 3'b001,
    ACP_PH_WDATA  = 3'b010,
    ACP_PH_RDATA  = 3'b011,
    ACP_PH_IGNORE = 3'b100
  } acp_phase_t;

  // Host states
  typedef enum logic [2:0] {
    ACP_HS_BOOT = 3'b000,
    ACP_HS_IDLE = 3'b001,
    ACP_HS_LOW  = 3'b010,
    ACP_HS_HIGH = 3'b011,
    ACP_HS_TAIL = 3'b100,
    ACP_HS_GAP  = 3'b101
  } acp_hstate_t;

  // Host command kinds
  typedef enum logic [1:0] {
    ACP_OP_WRITE  = 2'b00,
    ACP_OP_SETPTR = 2'b01,
    ACP_OP_READ   = 2'b10
  } acp_op_t;

  // Pointer advance, shared by reads and writes
  function automatic logic [7:0] acp_ptr_inc(input logic [7:0] p);
    acp_ptr_inc = p + 8'h01;
  endfunction

endpackage

// ---- verilog/acp_link_if.sv ----
`timescale 1ns/1ps
interface acp_link_if;
  logic addr_lsb_or_select_pin_n;   // Select, low during a frame
  logic control_bit_clock;          // Link clock from the host
  logic control_serial_in;          // Host to device data
  logic control_serial_out;         // Device output value
  logic control_serial_out_oe_n;    // Low while the device drives
  logic control_serial_out_line;    // Resolved wire level

  // No pull on the line: undriven, it shows the inverse of the last value,
  // so a sample taken outside the driven window reads the wrong bit
  assign control_serial_out_line = control_serial_out_oe_n ? ~control_serial_out : control_serial_out;

  modport dev (
    input  addr_lsb_or_select_pin_n,
    input  control_bit_clock,
    input  control_serial_in,
    output control_serial_out,
    output control_serial_out_oe_n
  );

  modport host (
    output addr_lsb_or_select_pin_n,
    output control_bit_clock,
    output control_serial_in,
    input  control_serial_out_line
  );
endinterface

// ---- verilog/acp_host.sv ----
`timescale 1ns/1ps
module acp_host
  import acp_pkg::*;
(
  input  wire logic         clk_i,        // System clock
  input  wire logic         rst_i,        // Asynchronous reset, active high
  acp_link_if.host          link,         // Control port pins
  input  wire logic         cmd_valid_i,  // Command request, taken when idle
  input  wire acp_op_t      cmd_op_i,     // Write, pointer set or read
  input  wire logic [7:0]   cmd_ptr_i,    // Register pointer for write or set
  input  wire logic [7:0]   cmd_data_i,   // Data for a write
  output logic              busy_o,       // Command in progress
  output logic              rd_valid_o,   // One-cycle pulse with read data
  output logic [7:0]        rd_data_o     // Byte returned by a read
);

  // Whole host state
  typedef struct packed {
    acp_hstate_t st;       // Sequencer state
    logic [7:0]  cnt;      // Half-period and gap counter
    logic [4:0]  nbits;    // Bits left in the frame
    logic [23:0] tx;       // Outgoing bits, MSB first
    logic [7:0]  rx;       // Last eight bits sampled
    logic        rd;       // Frame is a read
    logic        cs_n;     // Select pin
    logic        sck;      // Link clock, divided from clk_i
    logic        sdi;      // Serial data to the device
    logic        busy;     // Busy flag
    logic        rd_valid; // Read data pulse
    logic [7:0]  rd_data;  // Read data
    logic        so_s1;    // Returned data, first stage
    logic        so_s2;    // Returned data, second stage
  } acp_host_t;

  acp_host_t h_r, h_nxt;   // State and next state

  // Sequencer
  always_comb begin
    h_nxt          = h_r;
    h_nxt.so_s1    = link.control_serial_out_line;
    h_nxt.so_s2    = h_r.so_s1;
    h_nxt.rd_valid = 1'b0;
    h_nxt.cnt      = h_r.cnt - 8'h01;
    unique case (h_r.st)
      ACP_HS_BOOT: begin
        // Keep select high for the settle time after reset
        if (h_r.cnt == 8'h00) begin
          h_nxt.st   = ACP_HS_IDLE;
          h_nxt.busy = 1'b0;
        end
      end
      ACP_HS_IDLE: begin
        // Pins stay static while idle
        h_nxt.cnt = h_r.cnt;
        if (cmd_valid_i) begin
          h_nxt.busy = 1'b1;
          h_nxt.rd   = (cmd_op_i == ACP_OP_READ);
          if (cmd_op_i == ACP_OP_READ) begin
            h_nxt.tx    = {ACP_CHIP_ADDR, ACP_RW_READ, 16'h0000};
            h_nxt.nbits = ACP_BITS_SHORT;
          end else begin
            h_nxt.tx    = {ACP_CHIP_ADDR, ACP_RW_WRITE, cmd_ptr_i, cmd_data_i};
            // A pointer set stops after the pointer byte, ahead of a read
            h_nxt.nbits = (cmd_op_i == ACP_OP_WRITE) ? ACP_BITS_WRITE : ACP_BITS_SHORT;
          end
          h_nxt.sdi  = ACP_CHIP_ADDR[6];
          h_nxt.cs_n = 1'b0;
          h_nxt.cnt  = ACP_HALF_LOAD;
          h_nxt.st   = ACP_HS_LOW;
        end
      end
      ACP_HS_LOW: begin
        // Rising edge: device samples, host samples returned bit
        if (h_r.cnt == 8'h00) begin
          h_nxt.sck   = 1'b1;
          h_nxt.rx    = {h_r.rx[6:0], h_r.so_s2};
          h_nxt.nbits = h_r.nbits - 5'h01;
          h_nxt.cnt   = ACP_HALF_LOAD;
          h_nxt.st    = ACP_HS_HIGH;
        end
      end
      ACP_HS_HIGH: begin
        // Falling edge: next bit out, or finish the frame
        if (h_r.cnt == 8'h00) begin
          h_nxt.sck = 1'b0;
          h_nxt.cnt = ACP_HALF_LOAD;
          h_nxt.tx  = {h_r.tx[22:0], 1'b0};
          h_nxt.sdi = h_r.tx[22];
          h_nxt.st  = (h_r.nbits == 5'h00) ? ACP_HS_TAIL : ACP_HS_LOW;
        end
      end
      ACP_HS_TAIL: begin
        // Release select half a period after the last falling edge
        if (h_r.cnt == 8'h00) begin
          h_nxt.cs_n     = 1'b1;
          h_nxt.sdi      = 1'b0;
          h_nxt.rd_valid = h_r.rd;
          h_nxt.rd_data  = h_r.rd ? h_r.rx : h_r.rd_data;
          h_nxt.cnt      = ACP_CSH_LOAD;
          h_nxt.st       = ACP_HS_GAP;
        end
      end
      ACP_HS_GAP: begin
        // Select high time between frames
        if (h_r.cnt == 8'h00) begin
          h_nxt.busy = 1'b0;
          h_nxt.st   = ACP_HS_IDLE;
        end
      end
      default: begin
        h_nxt.st = ACP_HS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      h_r <= '{st: ACP_HS_BOOT, cnt: ACP_SRS_LOAD, nbits: 5'h00, tx: 24'h000000,
               rx: 8'h00, rd: 1'b0, cs_n: 1'b1, sck: 1'b0, sdi: 1'b0, busy: 1'b1,
               rd_valid: 1'b0, rd_data: 8'h00, so_s1: 1'b0, so_s2: 1'b0};
    end else begin
      h_r <= h_nxt;
    end
  end

  assign link.addr_lsb_or_select_pin_n = h_r.cs_n;
  assign link.control_bit_clock        = h_r.sck;
  assign link.control_serial_in        = h_r.sdi;
  assign busy_o                        = h_r.busy;
  assign rd_valid_o                    = h_r.rd_valid;
  assign rd_data_o                     = h_r.rd_data;

endmodule

// ---- verif/acp_props.sv ----
`timescale 1ns/1ps
module acp_props
  import acp_pkg::*;
(
  input wire logic clk_i,                    // System clock
  input wire logic rst_i,                    // Reset, active high
  input wire logic addr_lsb_or_select_pin_n, // Select, low in a frame
  input wire logic control_bit_clock,        // Link clock
  input wire logic control_serial_in,        // Host to device data
  input wire logic control_serial_out,       // Device data value
  input wire logic control_serial_out_oe_n   // Low while device drives
);
  localparam logic [7:0] HI_CYC  = 8'(ACP_SCK_HALF_CYC);  // Link clock high samples
  localparam logic [8:0] GAP_MIN = 9'(ACP_CSH_CYC - 1);   // Sampling may lose one cycle
  logic       sck_q_r; // Link clock one cycle ago
  logic [5:0] cnt_r;   // Rising link edges in this frame
  logic [7:0] hdr_r;   // First byte of this frame
  logic [7:0] hi_r;    // Samples with the link clock high
  logic [8:0] gap_r;   // Samples with select high, saturating
  logic       rise;    // Rising link edge seen now
  logic       rd_hit;  // Frame is a read to our address

  assign rise   = control_bit_clock & ~sck_q_r;
  assign rd_hit = (cnt_r >= 6'h08) && (hdr_r == {ACP_CHIP_ADDR, ACP_RW_READ});

  // Frame tracking; reset counts as a fresh gap so the first frame is not flagged
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_q_r <= 1'b0;
      cnt_r   <= 6'h00;
      hdr_r   <= 8'h00;
      hi_r    <= 8'h00;
      gap_r   <= 9'(ACP_CSH_CYC);
    end else begin
      sck_q_r <= control_bit_clock;
      hi_r    <= control_bit_clock ? hi_r + 8'h01 : 8'h00;
      if (addr_lsb_or_select_pin_n) begin
        cnt_r <= 6'h00;
        gap_r <= (gap_r == 9'h1FF) ? gap_r : gap_r + 9'h001;
      end else begin
        gap_r <= 9'h000;
        if (rise) begin
          cnt_r <= cnt_r + 6'h01;
          hdr_r <= (cnt_r < 6'h08) ? {hdr_r[6:0], control_serial_in} : hdr_r;
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_idle_undriven: assert property (addr_lsb_or_select_pin_n |-> control_serial_out_oe_n)
    else $error("serial out driven while deselected");
  a_write_no_drive: assert property (!addr_lsb_or_select_pin_n && !rd_hit |-> control_serial_out_oe_n)
    else $error("serial out driven outside a matching read");
  a_read_drive_msb: assert property (
    $fell(control_bit_clock) && cnt_r == 6'h08 && rd_hit |-> ##[0:2] !control_serial_out_oe_n)
    else $error("read data not driven after eighth bit");
  a_out_on_fall: assert property (
    !control_serial_out_oe_n && !$past(control_serial_out_oe_n)
    && $changed(control_serial_out) |-> $fell(control_bit_clock))
    else $error("serial out changed off the falling edge");
  a_in_while_low: assert property ($changed(control_serial_in) |-> !control_bit_clock)
    else $error("serial in changed while link clock high");
  a_addr_pattern: assert property (rise && cnt_r == 6'h07 |=> hdr_r[7:1] == ACP_CHIP_ADDR)
    else $error("chip address pattern wrong");
  a_frame_length: assert property (
    $rose(addr_lsb_or_select_pin_n) |-> cnt_r == 6'h10 || cnt_r == 6'h18)
    else $error("frame length wrong");
  a_idle_static: assert property (addr_lsb_or_select_pin_n && $past(addr_lsb_or_select_pin_n)
    |-> !control_bit_clock && $stable(control_serial_in))
    else $error("link pins move while idle");
  a_clock_high_time: assert property ($fell(control_bit_clock) |-> hi_r == HI_CYC)
    else $error("link clock high time wrong");
  a_select_gap: assert property ($fell(addr_lsb_or_select_pin_n) |-> gap_r >= GAP_MIN)
    else $error("select high time too short");

  c_write_frame: cover property ($rose(addr_lsb_or_select_pin_n) && cnt_r == 6'h18);
  c_read_drive: cover property (rd_hit && !control_serial_out_oe_n);
  c_back_to_back: cover property ($fell(addr_lsb_or_select_pin_n) && gap_r < 9'h100);
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import acp_pkg::*;
;
  logic        clk_i = 1'b0;            // System clock
  logic        rst_i = 1'b0;            // Reset, active high, raised by do_reset
  logic        cmd_valid_i = 1'b0;      // Host command request
  acp_op_t     cmd_op_i = ACP_OP_WRITE; // Host command kind
  logic [7:0]  cmd_ptr_i = 8'h00;       // Host pointer
  logic [7:0]  cmd_data_i = 8'h00;      // Host write data
  logic        busy_o, rd_valid_o;      // Host status
  logic [7:0]  rd_data_o;               // Host read data
  logic        wa_stb, wb_stb;          // Store pulses of both devices
  logic        mode_a, mode_b;          // Mode reports
  logic [7:0]  wa_addr, wa_data, wb_addr, wb_data;
  logic [15:0] qa[$], qb[$];            // Stored bytes seen, {pointer, data}
  logic [47:0] got;                     // Bits seen by the bench driver
  logic        b_drove = 1'b0;          // Second device drove its output
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n_rdv = 0;               // Read data pulses seen

  acp_link_if link_a();
  acp_link_if link_b();

  acp_host i_acp_host(.clk_i, .rst_i, .link(link_a), .cmd_valid_i, .cmd_op_i, .cmd_ptr_i,
    .cmd_data_i, .busy_o, .rd_valid_o, .rd_data_o);
  acp_device i_acp_device(.clk_i, .rst_i, .link(link_a), .spi_mode_o(mode_a),
    .wr_stb_o(wa_stb), .wr_addr_o(wa_addr), .wr_data_o(wa_data));
  // Second device faces the bench driver so faults can be injected
  acp_device i_acp_device_b(.clk_i, .rst_i, .link(link_b), .spi_mode_o(mode_b),
    .wr_stb_o(wb_stb), .wr_addr_o(wb_addr), .wr_data_o(wb_data));
  acp_props i_acp_props(.clk_i, .rst_i,
    .addr_lsb_or_select_pin_n(link_a.addr_lsb_or_select_pin_n),
    .control_bit_clock(link_a.control_bit_clock), .control_serial_in(link_a.control_serial_in),
    .control_serial_out(link_a.control_serial_out),
    .control_serial_out_oe_n(link_a.control_serial_out_oe_n));

  always #2.5 clk_i = ~clk_i;

  // Collect stored bytes and watch the second device's drive
  always @(posedge clk_i) begin
    if (wa_stb === 1'b1) qa.push_back({wa_addr, wa_data});
    if (wb_stb === 1'b1) qb.push_back({wb_addr, wb_data});
    if (rd_valid_o === 1'b1) n_rdv++;
    if (link_b.control_serial_out_oe_n !== 1'b1) b_drove = 1'b1;
  end

  // Hang guard; the full sequence needs about 14k cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      $display("ERROR at %0t ns: timeout", $time);
      end_sim();
    end
  end

  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Command inputs move 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
    n_compared++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  // Compare the oldest stored byte of one device; empty queue gives X
  task automatic pop_chk(input bit sel_b, input logic [15:0] exp_v);
    logic [15:0] v;
    v = 16'hXXXX;
    if (!sel_b && qa.size() > 0) v = qa.pop_front();
    if (sel_b && qb.size() > 0) v = qb.pop_front();
    chk(v, exp_v);
  endtask

  task automatic do_reset();
    rst_i = 1'b1;
    tick(5);
    rst_i = 1'b0;
  endtask

  // One host command, waiting until the host is idle before and after
  task automatic cmd(input acp_op_t op, input logic [7:0] ptr, input logic [7:0] dat);
    while (busy_o !== 1'b0) tick(1);
    cmd_op_i = op;
    cmd_ptr_i = ptr;
    cmd_data_i = dat;
    cmd_valid_i = 1'b1;
    tick(1);
    cmd_valid_i = 1'b0;
    while (busy_o !== 1'b0) tick(1);
  endtask

  // One read; the data pulse must come exactly once per read frame
  task automatic rd_chk(input logic [7:0] exp_v);
    int n0;
    n0 = n_rdv;
    cmd(ACP_OP_READ, 8'h00, 8'h00);
    chk({8'h00, rd_data_o}, {8'h00, exp_v});
    chk(16'(n_rdv - n0), 16'h0001);
  endtask

  // Bench frame on the second link: 6 ns link clock, MSB first, clock still outside
  task automatic bb(input logic [47:0] bits, input int n);
    got = 48'h0;
    link_b.addr_lsb_or_select_pin_n = 1'b0;
    #3;
    for (int i = n - 1; i >= 0; i--) begin
      link_b.control_serial_in = bits[i];
      #3 link_b.control_bit_clock = 1'b1;
      got = {got[46:0], link_b.control_serial_out_line};
      #3 link_b.control_bit_clock = 1'b0;
    end
    #3 link_b.addr_lsb_or_select_pin_n = 1'b1;
    tick(250); // Select stays high over 1 us
  endtask

  initial begin
    // Reset rises only once every process waits on its edge; the second link's
    // select is released after it, so its asynchronous frame clear sees an edge
    #1;
    do_reset();
    link_b.addr_lsb_or_select_pin_n = 1'b1;
    link_b.control_bit_clock = 1'b0;
    link_b.control_serial_in = 1'b0;
    chk({15'h0000, mode_a}, 16'h0000);
    cmd(ACP_OP_SETPTR, 8'h07, 8'h00);
    rd_chk(8'h00);
    chk({15'h0000, mode_a}, 16'h0001);
    chk({15'h0000, mode_b}, 16'h0000);
    // Writes at both ends of the store and one past it
    cmd(ACP_OP_WRITE, 8'h00, 8'hA5);
    pop_chk(1'b0, 16'h00A5);
    cmd(ACP_OP_WRITE, 8'h01, 8'h5A);
    pop_chk(1'b0, 16'h015A);
    cmd(ACP_OP_WRITE, 8'h0F, 8'hC3);
    pop_chk(1'b0, 16'h0FC3);
    cmd(ACP_OP_WRITE, 8'h10, 8'h3C);
    pop_chk(1'b0, 16'h103C);
    // Consecutive reads walk the pointer
    cmd(ACP_OP_SETPTR, 8'h00, 8'h00);
    rd_chk(8'hA5);
    rd_chk(8'h5A);
    cmd(ACP_OP_SETPTR, 8'h0F, 8'h00);
    rd_chk(8'hC3);
    rd_chk(8'h00);
    chk(16'(qa.size()), 16'h0000);
    // Wrong chip address on the second link: nothing stored, nothing driven
    b_drove = 1'b0;
    bb({24'h0, 8'h9C, 8'h02, 8'h55}, 24);
    bb({32'h0, 8'h9D, 8'h00}, 16);
    chk({15'h0000, b_drove}, 16'h0000);
    chk(16'(qb.size()), 16'h0000);
    // Block write ending in a partial byte
    bb({12'h000, 8'h9E, 8'h03, 8'h11, 8'h22, 4'h7}, 36);
    chk({15'h0000, b_drove}, 16'h0000);
    pop_chk(1'b1, 16'h0311);
    pop_chk(1'b1, 16'h0422);
    chk(16'(qb.size()), 16'h0000);
    // Block read from pointer 3
    bb({32'h0, 8'h9E, 8'h03}, 16);
    bb({24'h0, 8'h9F, 16'h0000}, 24);
    chk(got[15:0], 16'h1122);
    chk({15'h0000, link_b.control_serial_out_oe_n}, 16'h0001);
    // Aborted read keeps the pointer
    bb({32'h0, 8'h9E, 8'h04}, 16);
    bb({36'h0, 8'h9F, 4'h0}, 12);
    bb({32'h0, 8'h9F, 8'h00}, 16);
    chk({8'h00, got[7:0]}, 16'h0022);
    chk({15'h0000, mode_b}, 16'h0001);
    // Reset in mid-run returns defaults
    do_reset();
    chk({14'h0000, mode_a, mode_b}, 16'h0000);
    cmd(ACP_OP_SETPTR, 8'h00, 8'h00);
    rd_chk(8'h00);
    end_sim();
  end
endmodule
